// *** src/period_match_timer8.sv ***
// period match timer top: AHB-Lite slave, prescaler, counter, postscaler, flag
`timescale 1ns/1ps
module period_match_timer8
  import pmt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             matchOut,
  output logic             matchFlag
);
  pmt_regs_if regs ();

  // address phase capture
  logic     dWrite;
  logic     dRead;
  logic     dMapped;
  pmt_reg_t dSel;
  logic     addrTake;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == PMT_ADDR_CONTROL) || (a == PMT_ADDR_COUNT) ||
             (a == PMT_ADDR_PERIOD) || (a == PMT_ADDR_FLAGS);
  endfunction

  assign addrTake = hsel && hready && (htrans == PMT_HTRANS_NSEQ) && (hsize == PMT_HSIZE_WORD);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dWrite  <= 1'b0;
      dRead   <= 1'b0;
      dMapped <= 1'b0;
      dSel    <= PMT_REG_CONTROL;
    end else if (ce) begin
      if (hready) begin
        dWrite  <= addrTake && hwrite;
        dRead   <= addrTake && !hwrite;
        dMapped <= mapped(haddr);
        dSel    <= pmt_reg_t'(haddr[3:2]);
      end
    end
  end

  assign regs.wrStrobe  = ce && dWrite && dMapped;
  assign regs.wrSel     = dSel;
  assign regs.wrData    = hwdata[7:0];
  assign regs.flagClear = regs.wrStrobe && (dSel == PMT_REG_FLAGS) && !hwdata[PMT_FLAG_BIT];

  // period register
  logic [7:0] period;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      period <= PMT_PERIOD_RST;
    end else if (ce && regs.wrStrobe && regs.wrSel == PMT_REG_PERIOD) begin
      period <= regs.wrData;
    end
  end

  // read data answered one cycle after the address phase; zero-wait slave
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrTake && !hwrite && mapped(haddr)) begin
        unique case (pmt_reg_t'(haddr[3:2]))
          PMT_REG_CONTROL: hrdata <= {24'h000000, regs.control & PMT_CONTROL_MASK};
          PMT_REG_COUNT:   hrdata <= {24'h000000, regs.count};
          PMT_REG_PERIOD:  hrdata <= {24'h000000, period};
          PMT_REG_FLAGS:   hrdata <= {24'h000000, 6'h00, regs.flag, 1'b0};
        endcase
      end else if (addrTake) begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  pmt_core u_core (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .period (period),
    .regs   (regs.core),
    .match  (matchOut),
    .flag   (matchFlag)
  );

  property p_stopped_holds;
    @(posedge mclk) disable iff (!rst_n)
      (ce && !regs.control[PMT_RUN_BIT] && !(regs.wrStrobe && regs.wrSel == PMT_REG_COUNT))
      |=> (regs.count == $past(regs.count));
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("count moved while stopped");

  property p_ctrl_bit7_zero;
    @(posedge mclk) disable iff (!rst_n)
      regs.control[7] == 1'b0;
  endproperty
  a_ctrl_bit7_zero: assert property (p_ctrl_bit7_zero) else $error("control bit 7 stored");

  property p_period_write;
    @(posedge mclk) disable iff (!rst_n)
      (regs.wrStrobe && regs.wrSel == PMT_REG_PERIOD) |=> (period == $past(regs.wrData));
  endproperty
  a_period_write: assert property (p_period_write) else $error("period write lost");

  property p_wrap;
    @(posedge mclk) disable iff (!rst_n)
      (ce && u_core.matchNow) |=> (regs.count == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap after match");

  property p_reset_period;
    @(posedge mclk) !rst_n |=> (period == PMT_PERIOD_RST);
  endproperty
  a_reset_period: assert property (p_reset_period) else $error("period not all ones after reset");

  property p_match_cause;
    @(posedge mclk) disable iff (!rst_n)
      $rose(matchOut) |-> $past(u_core.tick) && ($past(regs.count) == $past(period));
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without equal count");

  property p_match_pulse;
    @(posedge mclk) disable iff (!rst_n)
      (matchOut && ce) |=> !matchOut;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match longer than one cycle");

  property p_flag_from_match;
    @(posedge mclk) disable iff (!rst_n)
      $rose(matchFlag) |-> $past(u_core.postDone);
  endproperty
  a_flag_from_match: assert property (p_flag_from_match) else $error("flag set without postscale end");

  property p_ctrl_keeps_count;
    @(posedge mclk) disable iff (!rst_n)
      (regs.wrStrobe && regs.wrSel == PMT_REG_CONTROL)
      |=> (regs.count == $past(regs.count));
  endproperty
  a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("control write changed count");

  property p_post_div1;
    @(posedge mclk) disable iff (!rst_n)
      (ce && u_core.matchNow && regs.control[PMT_POST_MSB:PMT_POST_LSB] == 4'h0 && !regs.wrStrobe)
      |=> matchFlag;
  endproperty
  a_post_div1: assert property (p_post_div1) else $error("1:1 postscale missed a match");

  property p_count_step;
    @(posedge mclk) disable iff (!rst_n)
      (ce && u_core.tick && !u_core.scalerClear && regs.count != period)
      |=> (regs.count == $past(regs.count) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step by one");

  property p_scaler_clear;
    @(posedge mclk) disable iff (!rst_n)
      (regs.wrStrobe && (regs.wrSel == PMT_REG_COUNT || regs.wrSel == PMT_REG_CONTROL))
      |=> (u_core.u_pre.cnt == 4'h0) && (u_core.u_post.cnt == 4'h0);
  endproperty
  a_scaler_clear: assert property (p_scaler_clear) else $error("scalers not cleared by write");

  property p_tick_needs_run;
    @(posedge mclk) disable iff (!rst_n)
      u_core.tick |-> regs.control[PMT_RUN_BIT];
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run) else $error("tick while timer stopped");

  property p_instr_rate;
    @(posedge mclk) disable iff (!rst_n)
      (ce && u_core.instrTick) |=> (u_core.instrDiv == 2'h0);
  endproperty
  a_instr_rate: assert property (p_instr_rate) else $error("instruction divider out of step");

  property p_flag_clear;
    @(posedge mclk) disable iff (!rst_n)
      (regs.flagClear && !u_core.postDone) |=> !matchFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");
endmodule

module pmt_core
  import pmt_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [7:0] period,
  pmt_regs_if.core        regs,
  output logic            match,
  output logic            flag
);
  logic [7:0] control;
  logic [7:0] count;
  logic [1:0] instrDiv;
  logic       instrTick;
  logic       tick;
  logic       matchNow;
  logic       postDone;
  logic       scalerClear;
  logic [3:0] preLimit;

  assign regs.control = control;
  assign regs.count   = count;
  assign regs.flag    = flag;

  // any count or control write restarts both scalers
  assign scalerClear = regs.wrStrobe && (regs.wrSel == PMT_REG_COUNT || regs.wrSel == PMT_REG_CONTROL);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control <= PMT_CONTROL_RST;
    end else if (ce && regs.wrStrobe && regs.wrSel == PMT_REG_CONTROL) begin
      control <= regs.wrData & PMT_CONTROL_MASK;
    end
  end

  // instruction clock: one tick every four mclk cycles
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      instrDiv <= 2'h0;
    end else if (ce) begin
      instrDiv <= instrDiv + 2'h1;
    end
  end
  assign instrTick = (instrDiv == PMT_INSTR_DIV) && control[PMT_RUN_BIT];

  always_comb begin
    if (control[PMT_PRE_MSB]) begin
      preLimit = PMT_PRE_DIV16;
    end else if (control[0]) begin
      preLimit = PMT_PRE_DIV4;
    end else begin
      preLimit = 4'h0;
    end
  end

  pmt_scaler #(.WIDTH(4)) u_pre (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (scalerClear),
    .tick  (instrTick),
    .limit (preLimit),
    .done  (tick)
  );

  assign matchNow = tick && (count == period) && !scalerClear;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= PMT_COUNT_RST;
    end else if (ce) begin
      if (regs.wrStrobe && regs.wrSel == PMT_REG_COUNT) begin
        count <= regs.wrData;
      end else if (tick && !scalerClear) begin
        count <= (count == period) ? 8'h00 : count + 8'h01;
      end
    end
  end

  pmt_scaler #(.WIDTH(4)) u_post (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (scalerClear),
    .tick  (matchNow),
    .limit (control[PMT_POST_MSB:PMT_POST_LSB]),
    .done  (postDone)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      match <= 1'b0;
    end else if (ce) begin
      match <= matchNow;
    end
  end

  // set wins over a simultaneous software clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (postDone) begin
        flag <= 1'b1;
      end else if (regs.flagClear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

// *** src/pmt_pkg.sv ***
// constants, register map and types of the period match timer
//
// Operation
// - Postscale field code n in control bits 6..3 divides match events by n+1, 1:1 up to 1:16.
// - The counter advances only while the run bit at control bit 2 is one.
// - Prescale field in control bits 1..0 divides by 1 for 00, by 4 for 01, by 16 when the upper bit is set.
// - Control bit 7 has no storage and always reads zero.
// - The 8-bit period register is readable and writable.
// - The count rises from zero on each prescaled tick and returns to zero on the tick after it equals the period.
// - Reset loads the period register with all ones.
// - The match output ahead of the postscaler is exported as a shift-clock source for the serial port.
// - The prescaler is clocked from the instruction clock, a quarter of the oscillator rate.
// - Each completed postscaler count sets the match interrupt flag, bit 1 of the peripheral request flags.
// - A write to the count register, a write to the control register and reset clear both scaler counters.
// - A control write leaves the count alone; reset clears the count.
package pmt_pkg;
  localparam logic [31:0] PMT_ADDR_CONTROL = 32'h0000_0000;
  localparam logic [31:0] PMT_ADDR_COUNT   = 32'h0000_0004;
  localparam logic [31:0] PMT_ADDR_PERIOD  = 32'h0000_0008;
  localparam logic [31:0] PMT_ADDR_FLAGS   = 32'h0000_000C;
  localparam int          PMT_POST_LSB     = 3;
  localparam int          PMT_POST_MSB     = 6;
  localparam int          PMT_RUN_BIT      = 2;
  localparam int          PMT_PRE_MSB      = 1;
  localparam int          PMT_FLAG_BIT     = 1;
  localparam logic [7:0]  PMT_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  PMT_COUNT_RST    = 8'h00;
  localparam logic [7:0]  PMT_PERIOD_RST   = 8'hFF;
  localparam logic [7:0]  PMT_CONTROL_MASK = 8'h7F;
  localparam logic [1:0]  PMT_INSTR_DIV    = 2'h3;
  localparam logic [3:0]  PMT_PRE_DIV4     = 4'h3;
  localparam logic [3:0]  PMT_PRE_DIV16    = 4'hF;
  localparam logic [1:0]  PMT_HTRANS_NSEQ  = 2'h2;
  localparam logic [2:0]  PMT_HSIZE_WORD   = 3'h2;
  typedef enum logic [1:0] {
    PMT_REG_CONTROL = 2'b00,
    PMT_REG_COUNT   = 2'b01,
    PMT_REG_PERIOD  = 2'b10,
    PMT_REG_FLAGS   = 2'b11
  } pmt_reg_t;
endpackage

// *** src/pmt_regs_if.sv ***
// register write strobes and control fields between slave and timer core
`timescale 1ns/1ps
interface pmt_regs_if;
  logic       wrStrobe;
  pmt_pkg::pmt_reg_t wrSel;
  logic [7:0] wrData;
  logic [7:0] control;
  logic [7:0] count;
  logic       flag;
  logic       flagClear;
  modport slave (output wrStrobe, output wrSel, output wrData, output flagClear,
                 input control, input count, input flag);
  modport core  (input wrStrobe, input wrSel, input wrData, input flagClear,
                 output control, output count, output flag);
endinterface

// *** src/pmt_scaler.sv ***
// shared divide-by-(limit+1) event counter used for prescale and postscale
`timescale 1ns/1ps
module pmt_scaler #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  done
);
  logic [WIDTH-1:0] cnt;
  // done pulses on the tick that completes limit+1 ticks
  assign done = tick && (cnt >= limit);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (ce) begin
      if (clear) begin
        cnt <= '0;
      end else if (done) begin
        cnt <= '0;
      end else if (tick) begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the period match timer over its bus port
`timescale 1ns/1ps
module tb_top
  import pmt_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        matchOut;
  logic        matchFlag;
  int          errCount;
  int          checks;
  logic [31:0] rd;

  period_match_timer8 u_period_match_timer8 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .matchOut  (matchOut),
    .matchFlag (matchFlag)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (errCount == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // single word transfer; address phase then data phase, each held until hready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= PMT_HTRANS_NSEQ;
    hsize  <= PMT_HSIZE_WORD;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      errCount++;
      $display("MISMATCH hready expected 1 seen %b", hreadyout);
    end
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(name, exp, q);
  endtask

  // cycles until the next match pulse
  task automatic wait_match(output int cyc);
    cyc = 0;
    do begin
      @(posedge mclk);
      cyc++;
    end while (matchOut !== 1'b1 && cyc < 3000);
  endtask

  task automatic t_reset_values();
    rdchk("control rst", PMT_ADDR_CONTROL, 32'h0000_0000);
    rdchk("count rst", PMT_ADDR_COUNT, 32'h0000_0000);
    rdchk("period rst", PMT_ADDR_PERIOD, 32'h0000_00FF);
    rdchk("flags rst", PMT_ADDR_FLAGS, 32'h0000_0000);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic t_registers();
    wr(PMT_ADDR_CONTROL, 32'hFFFF_FFFB);
    rdchk("control bit7", PMT_ADDR_CONTROL, 32'h0000_007B);
    wr(PMT_ADDR_CONTROL, 32'h0000_0000);
    wr(PMT_ADDR_PERIOD, 32'h0000_00A5);
    rdchk("period rw", PMT_ADDR_PERIOD, 32'h0000_00A5);
    wr(32'h0000_0010, 32'h0000_00FF);
    rdchk("unmapped", 32'h0000_0010, 32'h0000_0000);
  endtask

  task automatic t_run_stop();
    wr(PMT_ADDR_COUNT, 32'h0000_0005);
    repeat (40) @(posedge mclk);
    rdchk("stopped count", PMT_ADDR_COUNT, 32'h0000_0005);
    wr(PMT_ADDR_CONTROL, 32'h0000_0079);
    rdchk("count after ctl wr", PMT_ADDR_COUNT, 32'h0000_0005);
    wr(PMT_ADDR_CONTROL, 32'h0000_0004);
    repeat (40) @(posedge mclk);
    bus(1'b0, PMT_ADDR_COUNT, 32'h0, rd);
    check("count moved", 32'h1, {31'h0, rd !== 32'h0000_0005});
  endtask

  // match spacing for every prescale code and two periods
  task automatic t_prescale();
    int cyc;
    int div [4] = '{1, 4, 16, 16};
    int per [2] = '{3, 0};
    for (int p = 0; p < 2; p++) begin
      wr(PMT_ADDR_PERIOD, 32'(per[p]));
      for (int c = 0; c < 4; c++) begin
        wr(PMT_ADDR_CONTROL, 32'h0000_0004 | 32'(c));
        wr(PMT_ADDR_COUNT, 32'h0000_0000);
        wait_match(cyc);
        @(posedge mclk);
        check("pulse width", 32'h0, {31'h0, matchOut});
        wait_match(cyc);
        check("match spacing", 32'(4 * div[c] * (per[p] + 1)), 32'(cyc + 1));
      end
    end
  endtask

  // matches counted per flag set for postscale codes 0, 1 and 15
  task automatic t_postscale();
    int k;
    int n;
    int codes [3] = '{0, 1, 15};
    wr(PMT_ADDR_PERIOD, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      wr(PMT_ADDR_CONTROL, 32'h0000_0004 | 32'(codes[i] << 3));
      wr(PMT_ADDR_COUNT, 32'h0000_0000);
      wr(PMT_ADDR_FLAGS, 32'h0000_0000);
      k = 0;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
        if (matchOut === 1'b1) k++;
      end while (matchFlag !== 1'b1 && n < 2000);
      check("matches per flag", 32'(codes[i] + 1), 32'(k));
      rdchk("flag bit", PMT_ADDR_FLAGS, 32'h0000_0002);
    end
    wr(PMT_ADDR_CONTROL, 32'h0000_0000);
    wr(PMT_ADDR_FLAGS, 32'h0000_0000);
    rdchk("flag cleared", PMT_ADDR_FLAGS, 32'h0000_0000);
  endtask

  // bus writes are ignored while the clock enable is low
  task automatic t_clock_enable();
    wr(PMT_ADDR_PERIOD, 32'h0000_003C);
    @(posedge mclk);
    ce <= 1'b0;
    wr(PMT_ADDR_PERIOD, 32'h0000_0055);
    ce <= 1'b1;
    rdchk("period frozen", PMT_ADDR_PERIOD, 32'h0000_003C);
  endtask

  task automatic t_mid_reset();
    wr(PMT_ADDR_PERIOD, 32'h0000_0012);
    wr(PMT_ADDR_COUNT, 32'h0000_0009);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk("period after rst", PMT_ADDR_PERIOD, 32'h0000_00FF);
    rdchk("count after rst", PMT_ADDR_COUNT, 32'h0000_0000);
  endtask

  initial begin
    errCount = 0;
    checks   = 0;
    rst_n    = 1'b0;
    ce       = 1'b1;
    hsel     = 1'b0;
    haddr    = 32'h0000_0000;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h0;
    hwdata   = 32'h0000_0000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset_values();
    t_registers();
    t_run_stop();
    t_prescale();
    t_postscale();
    t_clock_enable();
    t_mid_reset();
    print_verdict();
  end

  // cut a hang short well past the expected run length
  initial begin
    #(10 * 60000);
    errCount++;
    print_verdict();
  end
endmodule
